// >>> rtl/tpef_flag_cell.sv
// One sticky event flag with read-then-write-zero clearing.
// Assumes arm and clear are one-cycle qualifiers from the register slave.
`timescale 1ns/1ps
module tpef_flag_cell (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Control
  input wire logic event_in,
  input wire logic read_in,
  input wire logic write_zero_in,
  // State
  output logic flag_out
);
  logic armed;

  // Arm on a read seen while set; a new event cancels the arming
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      armed <= 1'b0;
    end else if (event_in) begin
      armed <= 1'b0;
    end else if (read_in && flag_out) begin
      armed <= 1'b1;
    end else if (write_zero_in) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_out <= 1'b0;
    end else if (event_in) begin
      flag_out <= 1'b1;
    end else if (write_zero_in && armed) begin
      flag_out <= 1'b0;
    end
  end

  event_wins_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    event_in |=> flag_out)
    else $error("event lost");
  clear_needs_arm_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    $fell(flag_out) |-> $past(armed) && $past(write_zero_in))
    else $error("flag cleared without read first");
  event_disarms_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    event_in |=> !armed)
    else $error("event did not reset clear");
endmodule

// >>> rtl/tpef_pkg.sv
// Package for the timer event flag block: register map, fields, resets.
// Assumes a single 40 MHz clock domain and 16-bit counter values.
package tpef_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_CH_MODE = 4'h3;
  localparam logic [3:0] ADDR_CH_VAL0 = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam int unsigned CTRL_CENTER_BIT = 0;
  localparam int unsigned CTRL_FREE_BIT = 1;
  localparam int unsigned STATUS_OVF_BIT = 0;
  localparam int unsigned STATUS_CH0_BIT = 1;
  localparam logic [15:0] CTR_ZERO = 16'h0000;
  localparam logic [15:0] CTR_TOP = 16'hffff;
  localparam logic [15:0] RESET_STATUS = 16'h0000;
  localparam logic [15:0] RESET_MASK = 16'h0000;
  localparam logic [1:0] RESET_CTRL = 2'h0;
  localparam logic [3:0] RESET_CH_MODE = 4'h0;
  localparam logic [15:0] RESET_CH_VAL = 16'h0000;
  // Channel mode nibble: [3:2] function, [1] edge_select_high,
  // [0] edge_select_low
  localparam logic [1:0] FUNC_CAPTURE = 2'h0;
  localparam logic [1:0] FUNC_COMPARE = 2'h1;
  localparam logic [1:0] FUNC_EPWM = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] modulo;
    logic count_up;
  } tpef_counter_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tpef_bus_s;
endpackage

// >>> rtl/tpef_top.sv
// Event flags and interrupt requests of a multi-channel 16-bit timer.
// Assumes counter, modulo, direction and capture pins come from a
// datapath on the same clock; register port is a simple strobe bus.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module tpef_top #(
  parameter int unsigned NUM_CH = tpef_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Counter datapath
  input wire logic [15:0] count_in,
  input wire logic [15:0] modulo_in,
  input wire logic count_up_in,
  input wire logic [NUM_CH-1:0] capture_pin_in,
  // Interrupt requests
  output logic overflow_irq_out,
  output logic [NUM_CH-1:0] channel_irq_out,
  output logic irq_out
);
  tpef_pkg::tpef_counter_s ctr;
  tpef_pkg::tpef_counter_s ctr_prev;
  tpef_pkg::tpef_bus_s bus;
  logic [15:0] mask;
  logic [1:0] ctrl;
  logic [3:0] ch_mode [NUM_CH];
  logic [15:0] ch_val [NUM_CH];
  logic [NUM_CH-1:0] pin_prev;
  logic prev_valid;
  logic overflow_flag;
  logic [NUM_CH-1:0] channel_event_flag;
  logic overflow_event;
  logic [NUM_CH-1:0] channel_event;
  logic center_align_select;
  logic free_run;
  logic status_rd;
  logic status_wr;
  logic [15:0] status_word;
  logic [15:0] next_rdata;

  assign ctr = '{count: count_in, modulo: modulo_in, count_up: count_up_in};
  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign center_align_select = ctrl[tpef_pkg::CTRL_CENTER_BIT];
  assign free_run = ctrl[tpef_pkg::CTRL_FREE_BIT];
  assign status_rd = bus.rd && (bus.addr == tpef_pkg::ADDR_STATUS);
  assign status_wr = bus.wr && (bus.addr == tpef_pkg::ADDR_STATUS);

  // Counter reached the target value this cycle, from a different value
  function automatic logic moved_to(input logic [15:0] now,
                                    input logic [15:0] prev,
                                    input logic [15:0] target);
    moved_to = (now == target) && (prev != target);
  endfunction

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctr_prev <= '0;
      pin_prev <= '0;
      prev_valid <= 1'b0;
    end else begin
      ctr_prev <= ctr;
      pin_prev <= capture_pin_in;
      prev_valid <= 1'b1;
    end
  end

  // Overflow detection
  always_comb begin
    overflow_event = 1'b0;
    if (prev_valid) begin
      if (center_align_select) begin
        overflow_event = ctr_prev.count_up && !ctr.count_up &&
                         (ctr_prev.count == ctr_prev.modulo);
      end else if (free_run) begin
        overflow_event = (ctr_prev.count == tpef_pkg::CTR_TOP) &&
                         (ctr.count == tpef_pkg::CTR_ZERO);
      end else begin
        overflow_event = (ctr_prev.count == ctr_prev.modulo) &&
                         (ctr.count == tpef_pkg::CTR_ZERO);
      end
    end
  end

  // Channel event detection
  always_comb begin
    logic rise;
    logic fall;
    logic hit;
    channel_event = '0;
    rise = 1'b0;
    fall = 1'b0;
    hit = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      rise = capture_pin_in[i] && !pin_prev[i];
      fall = !capture_pin_in[i] && pin_prev[i];
      hit = prev_valid && moved_to(ctr.count, ctr_prev.count, ch_val[i]);
      if (center_align_select) begin
        // Center mode: a channel with its pin in use flags every match
        channel_event[i] = hit &&
          (ch_mode[i][1:0] != tpef_pkg::EDGE_NONE);
      end else begin
        case (ch_mode[i][3:2])
          tpef_pkg::FUNC_CAPTURE: begin
            case (ch_mode[i][1:0])
              tpef_pkg::EDGE_RISE: channel_event[i] = prev_valid && rise;
              tpef_pkg::EDGE_FALL: channel_event[i] = prev_valid && fall;
              tpef_pkg::EDGE_ANY: channel_event[i] = prev_valid &&
                                                     (rise || fall);
              default: channel_event[i] = 1'b0;
            endcase
          end
          tpef_pkg::FUNC_COMPARE: channel_event[i] = hit;
          default: channel_event[i] = hit;
        endcase
      end
    end
  end

  tpef_flag_cell overflow_cell (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .event_in(overflow_event),
    .read_in(status_rd),
    .write_zero_in(status_wr &&
                   !bus.wdata[tpef_pkg::STATUS_OVF_BIT]),
    .flag_out(overflow_flag)
  );

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    tpef_flag_cell channel_cell (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .event_in(channel_event[g]),
      .read_in(status_rd),
      .write_zero_in(status_wr &&
                     !bus.wdata[tpef_pkg::STATUS_CH0_BIT + g]),
      .flag_out(channel_event_flag[g])
    );
  end

  always_comb begin
    status_word = '0;
    status_word[tpef_pkg::STATUS_OVF_BIT] = overflow_flag;
    for (int i = 0; i < NUM_CH; i++) begin
      status_word[tpef_pkg::STATUS_CH0_BIT + i] = channel_event_flag[i];
    end
  end

  // Control registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mask <= tpef_pkg::RESET_MASK;
      ctrl <= tpef_pkg::RESET_CTRL;
    end else if (bus.wr) begin
      if (bus.addr == tpef_pkg::ADDR_MASK) begin
        mask <= bus.wdata & ((16'h0001 << (NUM_CH + 1)) - 16'h0001);
      end
      if (bus.addr == tpef_pkg::ADDR_CTRL) begin
        ctrl <= bus.wdata[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_mode[i] <= tpef_pkg::RESET_CH_MODE;
        ch_val[i] <= tpef_pkg::RESET_CH_VAL;
      end
    end else if (bus.wr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (bus.addr == tpef_pkg::ADDR_CH_MODE) begin
          ch_mode[i] <= bus.wdata[i*4 +: 4];
        end
        if (bus.addr == tpef_pkg::ADDR_CH_VAL0 + 4'(i)) begin
          ch_val[i] <= bus.wdata;
        end
      end
    end
  end

  // Read data, one cycle after the read strobe, zero otherwise
  always_comb begin
    next_rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        tpef_pkg::ADDR_STATUS: next_rdata = status_word;
        tpef_pkg::ADDR_MASK: next_rdata = mask;
        tpef_pkg::ADDR_CTRL: next_rdata = {14'h0000, ctrl};
        tpef_pkg::ADDR_CH_MODE: begin
          for (int i = 0; i < NUM_CH; i++) begin
            next_rdata[i*4 +: 4] = ch_mode[i];
          end
        end
        tpef_pkg::ADDR_COUNT: next_rdata = ctr.count;
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (bus.addr == tpef_pkg::ADDR_CH_VAL0 + 4'(i)) begin
              next_rdata = ch_val[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // Interrupt requests, registered, active high
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      overflow_irq_out <= 1'b0;
      channel_irq_out <= '0;
      irq_out <= 1'b0;
    end else begin
      overflow_irq_out <= overflow_flag &&
                          mask[tpef_pkg::STATUS_OVF_BIT];
      channel_irq_out <= channel_event_flag &
                         mask[tpef_pkg::STATUS_CH0_BIT +: NUM_CH];
      irq_out <= |(status_word & mask);
    end
  end

  // Interrupt request checks
  irq_follows_flag_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    overflow_flag && mask[0] |=> overflow_irq_out)
    else $error("overflow request missing");
  irq_needs_enable_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !mask[0] |=> !overflow_irq_out)
    else $error("overflow request while disabled");
  chan_irq_follows_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    channel_event_flag[1] && mask[2] |=> channel_irq_out[1])
    else $error("channel request missing");
  chan_irq_enable_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !mask[1] |=> !channel_irq_out[0])
    else $error("channel request while disabled");
  any_irq_high_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    |(status_word & mask) |=> irq_out)
    else $error("summary request missing");
  any_irq_low_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !(|(status_word & mask)) |=> !irq_out)
    else $error("summary request without cause");

  // Overflow checks
  wrap_sets_ovf_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && !free_run && prev_valid &&
    ctr_prev.count == ctr_prev.modulo && ctr.count == 16'h0000
    |=> overflow_flag)
    else $error("modulo wrap missed");
  free_wrap_ovf_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && free_run && prev_valid &&
    ctr_prev.count == 16'hffff && ctr.count == 16'h0000
    |=> overflow_flag)
    else $error("free wrap missed");
  free_no_modulo_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && free_run &&
    ctr_prev.count != 16'hffff |-> !overflow_event)
    else $error("free run wrapped early");
  turn_sets_ovf_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    center_align_select && prev_valid && $fell(ctr.count_up) &&
    ctr_prev.count == ctr_prev.modulo |=> overflow_flag)
    else $error("direction turn missed");
  center_no_wrap_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    center_align_select && ctr.count_up |-> !overflow_event)
    else $error("overflow while counting up");

  // Channel checks
  rise_capture_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && ch_mode[1] == 4'h1 && prev_valid &&
    $rose(capture_pin_in[1]) |=> channel_event_flag[1])
    else $error("rising capture missed");
  fall_capture_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && ch_mode[2] == 4'h2 && prev_valid &&
    $fell(capture_pin_in[2]) |=> channel_event_flag[2])
    else $error("falling capture missed");
  any_capture_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && ch_mode[3] == 4'h3 && prev_valid &&
    $changed(capture_pin_in[3]) |=> channel_event_flag[3])
    else $error("either edge capture missed");
  none_no_event_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && ch_mode[0] == 4'h0 |-> !channel_event[0])
    else $error("unused pin made event");
  compare_match_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && ch_mode[0][3:2] == 2'h1 && prev_valid &&
    ctr.count == ch_val[0] && ctr_prev.count != ch_val[0]
    |=> channel_event_flag[0])
    else $error("compare missed");
  epwm_match_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !center_align_select && ch_mode[1][3:2] == 2'h2 && prev_valid &&
    ctr.count == ch_val[1] && ctr_prev.count != ch_val[1]
    |=> channel_event_flag[1])
    else $error("duty end match missed");
  center_match_a: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    center_align_select && ch_mode[0][1:0] != 2'h0 && prev_valid &&
    ctr.count == ch_val[0] && ctr_prev.count != ch_val[0]
    |=> channel_event_flag[0])
    else $error("center duty match missed");
endmodule

// >>> tb/tpef_cpu_model.sv
// Register-side master standing in for the CPU core.
// Assumes one clock and a slave that never makes it wait.
`timescale 1ns/1ps
module tpef_cpu_model (
  // Clock
  input wire logic ref_clk_in,
  // Register port
  output logic [3:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial begin
    addr_out = 4'h0;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // Strobes stay up until the caller's next edge drops them
  task automatic release_bus();
    wr_out <= 1'b0;
    rd_out <= 1'b0;
  endtask

  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    rd_out <= 1'b0;
  endtask

  task automatic read_reg(input logic [3:0] a);
    @(posedge ref_clk_in);
    addr_out <= a;
    wr_out <= 1'b0;
    rd_out <= 1'b1;
  endtask
endmodule

// >>> tb/tpef_top_tb.sv
// Self-checking bench for the timer event flag block.
// Assumes the bench plays the counter datapath and capture pins.
`timescale 1ns/1ps
module tpef_top_tb;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [15:0] count = 16'h0000;
  logic [15:0] modulo = 16'h0010;
  logic count_up = 1'b1;
  logic [3:0] pins = 4'h0;
  logic ovf_irq;
  logic [3:0] ch_irq;
  logic irq;
  logic [15:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [15:0] v;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int i;

  always #12.5 ref_clk_in = ~ref_clk_in;

  tpef_cpu_model cpu (.ref_clk_in(ref_clk_in), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  tpef_top dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .count_in(count), .modulo_in(modulo),
    .count_up_in(count_up), .capture_pin_in(pins),
    .overflow_irq_out(ovf_irq), .channel_irq_out(ch_irq),
    .irq_out(irq));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read data is due in the cycle after the strobe
  always @(posedge ref_clk_in) begin
    if (rd_seen) begin
      check(rdata, exp_q.pop_front());
    end
    rd_seen <= rd;
    cycles++;
    if (cycles == 4000) begin
      errors++;
      complete_run();
    end
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_in);
      cpu.release_bus();
    end
  endtask

  task automatic rdx(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    cpu.read_reg(a);
  endtask

  task automatic cnt(input logic [15:0] c, input logic u);
    tick(1);
    count <= c;
    count_up <= u;
  endtask

  task automatic chk_irq(input logic [15:0] e);
    check({10'h000, irq, ch_irq, ovf_irq}, e);
  endtask

  // Read while set, then write zero, then confirm the flags dropped
  task automatic clr(input logic [15:0] e);
    rdx(tpef_pkg::ADDR_STATUS, e);
    cpu.write_reg(tpef_pkg::ADDR_STATUS, 16'h0000);
    tick(3);
    rdx(tpef_pkg::ADDR_STATUS, 16'h0000);
    tick(2);
  endtask

  task automatic wrap();
    cnt(16'h000f, 1'b1);
    cnt(16'h0010, 1'b1);
    cnt(16'h0000, 1'b1);
  endtask

  initial begin
    v = $urandom(32'h6dc9);
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    tick(2);
    rdx(tpef_pkg::ADDR_STATUS, tpef_pkg::RESET_STATUS);
    rdx(tpef_pkg::ADDR_MASK, tpef_pkg::RESET_MASK);
    rdx(tpef_pkg::ADDR_CTRL, {14'h0000, tpef_pkg::RESET_CTRL});
    rdx(tpef_pkg::ADDR_CH_MODE, 16'h0000);
    rdx(4'hf, 16'h0000);
    wrap();
    tick(3);
    chk_irq(16'h0000);
    cpu.write_reg(tpef_pkg::ADDR_STATUS, 16'h0000);
    tick(2);
    cpu.write_reg(tpef_pkg::ADDR_MASK, 16'h0001);
    tick(3);
    chk_irq(16'h0021);
    clr(16'h0001);
    chk_irq(16'h0000);
    wrap();
    rdx(tpef_pkg::ADDR_STATUS, 16'h0001);
    wrap();
    cpu.write_reg(tpef_pkg::ADDR_STATUS, 16'h0000);
    tick(3);
    rdx(tpef_pkg::ADDR_STATUS, 16'h0001);
    cnt(16'h000f, 1'b1);
    cnt(16'h0010, 1'b1);
    cpu.write_reg(tpef_pkg::ADDR_STATUS, 16'h0000);
    count <= 16'h0000;
    tick(3);
    clr(16'h0001);
    cpu.write_reg(tpef_pkg::ADDR_CTRL, 16'h0002);
    cnt(16'hffff, 1'b1);
    cnt(16'h0000, 1'b1);
    tick(3);
    clr(16'h0001);
    cpu.write_reg(tpef_pkg::ADDR_CTRL, 16'h0001);
    cpu.write_reg(tpef_pkg::ADDR_CH_MODE, 16'h0001);
    cpu.write_reg(tpef_pkg::ADDR_CH_VAL0, 16'h0003);
    modulo <= 16'h0008;
    for (i = 1; i <= 8; i++) cnt(16'(i), 1'b1);
    tick(3);
    clr(16'h0002);
    for (i = 7; i >= 3; i--) cnt(16'(i), 1'b0);
    tick(3);
    clr(16'h0003);
    cpu.write_reg(tpef_pkg::ADDR_CTRL, 16'h0000);
    v = 16'($urandom_range(32'h7fff, 32'h0100));
    cpu.write_reg(tpef_pkg::ADDR_CH_MODE, 16'h0084);
    cpu.write_reg(tpef_pkg::ADDR_CH_VAL0, v);
    cpu.write_reg(tpef_pkg::ADDR_CH_VAL0 + 4'h1, v + 16'h0010);
    cnt(v - 16'h0001, 1'b1);
    cnt(v, 1'b1);
    cnt(v + 16'h000f, 1'b1);
    cnt(v + 16'h0010, 1'b1);
    cpu.write_reg(tpef_pkg::ADDR_MASK, 16'h0006);
    tick(3);
    chk_irq(16'h0026);
    clr(16'h0006);
    chk_irq(16'h0000);
    cpu.write_reg(tpef_pkg::ADDR_CH_MODE, 16'h3210);
    tick(1);
    pins <= 4'hf;
    tick(3);
    clr(16'h0014);
    tick(1);
    pins <= 4'h0;
    tick(3);
    clr(16'h0018);
    tick(2);
    complete_run();
  end
endmodule
